/* File: hdl/slm_latency_regs.sv */
// latency mode register and auto-precharge delay logic
`timescale 1ns/10ps
// Operation
// - plain reads map code to latency and rtp
// - inverted reads use second latency table
// - set A write latency table
// - set B write latency table
// - bit 6 picks write latency set
// - bit 7 enables write leveling
// - leveling holds mrw state until cleared
// - access copy chosen by access set point
// - operating values from in-use set point
// - inactive copy never affects operating values
// - long bursts add eight clocks
// - read auto-precharge waits rtp clocks
// - write auto-precharge waits recovery clocks
// - latency register lives at address 2
// - io bit 6 enables read inversion
module slm_latency_regs (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic link_ck,
  input wire logic mrw_req,
  input wire logic mrr_req,
  input wire logic [5:0] mr_addr,
  input wire logic [7:0] mr_op,
  input wire logic set_point_for_access,
  input wire logic set_point_in_use,
  input wire logic rd_ap_done,
  input wire logic rd_ap_bl32,
  input wire logic wr_ap_done,
  input wire logic [5:0] recovery_cycles_after_store,
  output logic [7:0] mrr_data,
  output logic mrr_valid,
  output logic [5:0] read_latency,
  output logic [5:0] write_latency,
  output logic [4:0] read_to_precharge_cycles,
  output logic inversion_on_reads,
  output logic leveling_on,
  output logic precharge_start
);
  import slm_pkg::*;

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic [SLM_PIN_W-1:0] pin_s1;
    logic [SLM_PIN_W-1:0] pin_s2;
    logic ck_prev;
    logic [1:0][7:0] lat;
    logic [1:0][7:0] io;
    logic [7:0] rdata;
    logic rvalid;
    logic [5:0] rl;
    logic [5:0] wl;
    logic [4:0] rtp;
    logic inv;
    logic lev;
    slm_prc_t prc;
    logic [5:0] cnt;
    logic pre;
  } slm_state_t;

  slm_state_t st_ff;
  slm_state_t nxt_st;
  logic ck_s;
  logic ck_rise;
  logic c_mrw;
  logic c_mrr;
  logic [5:0] c_addr;
  logic [7:0] c_op;
  logic [7:0] lat_use;
  logic [7:0] io_use;
  logic [2:0] rl_code;
  logic [2:0] wl_code;

  assign {ck_s, c_mrw, c_mrr, c_addr, c_op} = st_ff.pin_s2;
  assign ck_rise = ck_s & ~st_ff.ck_prev;
  assign lat_use = st_ff.lat[set_point_in_use];
  assign io_use = st_ff.io[set_point_in_use];
  assign rl_code = lat_use[SLM_RL_LSB +: 3];
  assign wl_code = lat_use[SLM_WL_LSB +: 3];

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    nxt_st = st_ff;
    nxt_st.pin_s1 = {link_ck, mrw_req, mrr_req, mr_addr, mr_op};
    nxt_st.pin_s2 = st_ff.pin_s1;
    nxt_st.ck_prev = ck_s;
    nxt_st.rvalid = 1'b0;
    nxt_st.pre = 1'b0;
    if (ck_rise && c_mrw) begin
      if (c_addr == SLM_ADDR_LAT) begin
        nxt_st.lat[set_point_for_access] = c_op;
      end else if (c_addr == SLM_ADDR_IO) begin
        nxt_st.io[set_point_for_access] = c_op;
        // repair protection only clears at reset
        if (st_ff.io[set_point_for_access][SLM_REPAIR_PROTECTION_BIT]) begin
          nxt_st.io[set_point_for_access][SLM_REPAIR_PROTECTION_BIT] = 1'b1;
        end
      end
    end
    // reads refused while leveling
    if (ck_rise && c_mrr && !st_ff.lev) begin
      nxt_st.rvalid = 1'b1;
      if (c_addr == SLM_ADDR_LAT) begin
        nxt_st.rdata = st_ff.lat[set_point_for_access];
      end else if (c_addr == SLM_ADDR_IO) begin
        nxt_st.rdata = st_ff.io[set_point_for_access];
      end else begin
        nxt_st.rdata = 8'h00;
      end
    end
    nxt_st.inv = io_use[SLM_DBIRD_BIT];
    nxt_st.rl = io_use[SLM_DBIRD_BIT] ? SLM_RL_INV[rl_code] : SLM_RL_PLAIN[rl_code];
    nxt_st.rtp = SLM_RTP[rl_code][4:0];
    nxt_st.wl = lat_use[SLM_WLS_BIT] ? SLM_WL_B[wl_code] : SLM_WL_A[wl_code];
    nxt_st.lev = lat_use[SLM_LEV_BIT];
    unique case (st_ff.prc)
      SLM_PRC_IDLE: begin
      end
      SLM_PRC_WAIT: begin
        if (ck_rise) begin
          nxt_st.cnt = st_ff.cnt - 6'h01;
          if (st_ff.cnt <= 6'h01) begin
            nxt_st.pre = 1'b1;
            nxt_st.prc = SLM_PRC_IDLE;
          end
        end
      end
    endcase
    if (rd_ap_done) begin
      nxt_st.prc = SLM_PRC_WAIT;
      nxt_st.cnt = {1'b0, st_ff.rtp} + (rd_ap_bl32 ? SLM_BL32_EXTRA : 6'h00);
    end else if (wr_ap_done) begin
      nxt_st.prc = SLM_PRC_WAIT;
      nxt_st.cnt = recovery_cycles_after_store;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_ff <= '0;
      st_ff.lat <= {SLM_LAT_RST, SLM_LAT_RST};
      st_ff.io <= {SLM_IO_RST, SLM_IO_RST};
      st_ff.rl <= SLM_RL_PLAIN[0];
      st_ff.wl <= SLM_WL_A[0];
      st_ff.rtp <= SLM_RTP[0][4:0];
      st_ff.prc <= SLM_PRC_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign mrr_data = st_ff.rdata;
  assign mrr_valid = st_ff.rvalid;
  assign read_latency = st_ff.rl;
  assign write_latency = st_ff.wl;
  assign read_to_precharge_cycles = st_ff.rtp;
  assign inversion_on_reads = st_ff.inv;
  assign leveling_on = st_ff.lev;
  assign precharge_start = st_ff.pre;

  // ************************************************************
  // checks
  // ************************************************************
  property p_rl_table;
    @(posedge clk) disable iff (!rst_n)
    $past(rst_n) |-> read_latency == ($past(io_use[SLM_DBIRD_BIT]) ?
      SLM_RL_INV[$past(rl_code)] : SLM_RL_PLAIN[$past(rl_code)]);
  endproperty
  a_rl_table: assert property (p_rl_table) else $error("read latency mismatch");

  property p_rtp_table;
    @(posedge clk) disable iff (!rst_n)
    $past(rst_n) |-> read_to_precharge_cycles == SLM_RTP[$past(rl_code)][4:0];
  endproperty
  a_rtp_table: assert property (p_rtp_table) else $error("rtp mismatch");

  property p_wl_table;
    @(posedge clk) disable iff (!rst_n)
    $past(rst_n) |-> write_latency == ($past(lat_use[SLM_WLS_BIT]) ?
      SLM_WL_B[$past(wl_code)] : SLM_WL_A[$past(wl_code)]);
  endproperty
  a_wl_table: assert property (p_wl_table) else $error("write latency mismatch");

  property p_lev_hold;
    @(posedge clk) disable iff (!rst_n)
    leveling_on && $stable(set_point_in_use)
      && !$past(ck_rise && c_mrw && c_addr == SLM_ADDR_LAT) |=> leveling_on;
  endproperty
  a_lev_hold: assert property (p_lev_hold) else $error("leveling dropped");

  property p_mrw_copy;
    @(posedge clk) disable iff (!rst_n)
    ck_rise && c_mrw && c_addr == SLM_ADDR_LAT |=>
      st_ff.lat[$past(set_point_for_access)] == $past(c_op)
      && st_ff.lat[!$past(set_point_for_access)] == $past(st_ff.lat[!set_point_for_access]);
  endproperty
  a_mrw_copy: assert property (p_mrw_copy) else $error("wrong copy written");

  property p_mrr_lev;
    @(posedge clk) disable iff (!rst_n)
    leveling_on |=> !mrr_valid;
  endproperty
  a_mrr_lev: assert property (p_mrr_lev) else $error("read during leveling");

  property p_rd_load;
    @(posedge clk) disable iff (!rst_n)
    rd_ap_done |=> st_ff.prc == SLM_PRC_WAIT
      && st_ff.cnt == {1'b0, $past(st_ff.rtp)} + ($past(rd_ap_bl32) ? SLM_BL32_EXTRA : 6'h00);
  endproperty
  a_rd_load: assert property (p_rd_load) else $error("read delay load wrong");

  property p_wr_load;
    @(posedge clk) disable iff (!rst_n)
    wr_ap_done && !rd_ap_done |=> st_ff.cnt == $past(recovery_cycles_after_store);
  endproperty
  a_wr_load: assert property (p_wr_load) else $error("write delay load wrong");

  property p_pre_cause;
    @(posedge clk) disable iff (!rst_n)
    precharge_start |-> $past(st_ff.prc == SLM_PRC_WAIT && ck_rise && st_ff.cnt <= 6'h01);
  endproperty
  a_pre_cause: assert property (p_pre_cause) else $error("early precharge");

  property p_reset_dflt;
    @(posedge clk)
    !rst_n |=> st_ff.lat == {SLM_LAT_RST, SLM_LAT_RST} && !leveling_on;
  endproperty
  a_reset_dflt: assert property (p_reset_dflt) else $error("reset default lost");

  property p_rd_answer;
    @(posedge clk) disable iff (!rst_n)
    ck_rise && c_mrr && !leveling_on && c_addr == SLM_ADDR_LAT |=>
      mrr_valid && mrr_data == $past(st_ff.lat[set_point_for_access]);
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("wrong read copy");

  property p_mrr_cause;
    @(posedge clk) disable iff (!rst_n)
    mrr_valid |-> $past(ck_rise && c_mrr && !leveling_on);
  endproperty
  a_mrr_cause: assert property (p_mrr_cause) else $error("unrequested read answer");

  property p_other_addr;
    @(posedge clk) disable iff (!rst_n)
    ck_rise && c_mrw && c_addr != SLM_ADDR_LAT && c_addr != SLM_ADDR_IO |=>
      $stable(st_ff.lat) && $stable(st_ff.io);
  endproperty
  a_other_addr: assert property (p_other_addr) else $error("stray address written");

  property p_inactive_copy;
    @(posedge clk) disable iff (!rst_n)
    ck_rise && c_mrw && c_addr == SLM_ADDR_LAT && set_point_for_access != set_point_in_use
      ##1 $stable(set_point_in_use) |=>
      $stable(read_latency) && $stable(write_latency) && $stable(leveling_on);
  endproperty
  a_inactive_copy: assert property (p_inactive_copy) else $error("inactive copy leaked");

  property p_inv_src;
    @(posedge clk) disable iff (!rst_n)
    $past(rst_n) |-> inversion_on_reads == $past(io_use[SLM_DBIRD_BIT]);
  endproperty
  a_inv_src: assert property (p_inv_src) else $error("inversion source wrong");

  property p_lev_src;
    @(posedge clk) disable iff (!rst_n)
    $past(rst_n) |-> leveling_on == $past(lat_use[SLM_LEV_BIT]);
  endproperty
  a_lev_src: assert property (p_lev_src) else $error("leveling source wrong");

  property p_pre_pulse;
    @(posedge clk) disable iff (!rst_n)
    precharge_start |=> !precharge_start;
  endproperty
  a_pre_pulse: assert property (p_pre_pulse) else $error("precharge start too long");

  property p_idle_quiet;
    @(posedge clk) disable iff (!rst_n)
    st_ff.prc == SLM_PRC_IDLE |=> !precharge_start;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("precharge without burst");

  property p_cnt_step;
    @(posedge clk) disable iff (!rst_n)
    st_ff.prc == SLM_PRC_WAIT && ck_rise && st_ff.cnt > 6'h01 && !rd_ap_done && !wr_ap_done
      |=> st_ff.prc == SLM_PRC_WAIT && st_ff.cnt == $past(st_ff.cnt) - 6'h01;
  endproperty
  a_cnt_step: assert property (p_cnt_step) else $error("delay count step wrong");

  property p_cnt_hold;
    @(posedge clk) disable iff (!rst_n)
    st_ff.prc == SLM_PRC_WAIT && !ck_rise && !rd_ap_done && !wr_ap_done
      |=> st_ff.prc == SLM_PRC_WAIT && $stable(st_ff.cnt);
  endproperty
  a_cnt_hold: assert property (p_cnt_hold) else $error("delay count moved");

  c_lev: cover property (@(posedge clk) disable iff (!rst_n) $rose(leveling_on));
  c_pre: cover property (@(posedge clk) disable iff (!rst_n) precharge_start);
  c_rd_answer: cover property (@(posedge clk) disable iff (!rst_n) mrr_valid);
  c_long_burst: cover property (@(posedge clk) disable iff (!rst_n) rd_ap_done && rd_ap_bl32);
  c_inactive_wr: cover property (@(posedge clk) disable iff (!rst_n)
    ck_rise && c_mrw && set_point_for_access != set_point_in_use);
endmodule // slm_latency_regs

/* File: shared/slm_pkg.sv */
// constants for the latency mode register block
package slm_pkg;
  // ************************************************************
  // addresses and field layout
  // ************************************************************
  localparam logic [5:0] SLM_ADDR_LAT = 6'h02;
  localparam logic [5:0] SLM_ADDR_IO = 6'h03;
  localparam int SLM_RL_LSB = 0;
  localparam int SLM_WL_LSB = 3;
  localparam int SLM_WLS_BIT = 6;
  localparam int SLM_LEV_BIT = 7;
  localparam int SLM_REPAIR_PROTECTION_BIT = 2;
  localparam int SLM_DBIRD_BIT = 6;
  localparam logic [7:0] SLM_LAT_RST = 8'h00;
  localparam logic [7:0] SLM_IO_RST = 8'h31;
  localparam logic [5:0] SLM_BL32_EXTRA = 6'h08;

  // ************************************************************
  // latency tables, entry i is code i
  // ************************************************************
  localparam logic [7:0][5:0] SLM_RL_PLAIN = {6'h24, 6'h20, 6'h1C, 6'h18,
                                              6'h14, 6'h0E, 6'h0A, 6'h06};
  localparam logic [7:0][5:0] SLM_RL_INV = {6'h28, 6'h24, 6'h20, 6'h1C,
                                            6'h16, 6'h10, 6'h0C, 6'h06};
  localparam logic [7:0][5:0] SLM_WL_A = {6'h12, 6'h10, 6'h0E, 6'h0C,
                                          6'h0A, 6'h08, 6'h06, 6'h04};
  localparam logic [7:0][5:0] SLM_WL_B = {6'h22, 6'h1E, 6'h1A, 6'h16,
                                          6'h12, 6'h0C, 6'h08, 6'h04};
  localparam logic [7:0][5:0] SLM_RTP = {6'h10, 6'h0E, 6'h0C, 6'h0A,
                                         6'h08, 6'h08, 6'h08, 6'h08};

  typedef enum logic {
    SLM_PRC_IDLE = 1'b0,
    SLM_PRC_WAIT = 1'b1
  } slm_prc_t;

  localparam int SLM_PIN_W = 17;
endpackage

/* File: dv/slm_ctrl_model.sv */
// controller model issuing mode register commands
`timescale 1ns/10ps
module slm_ctrl_model (
  output logic link_ck,
  output logic mrw_req,
  output logic mrr_req,
  output logic [5:0] mr_addr,
  output logic [7:0] mr_op
);
  initial begin
    link_ck = 1'b0;
    mrw_req = 1'b0;
    mrr_req = 1'b0;
    mr_addr = 6'h3F;
    mr_op = 8'hFF;
  end
  // free command clock, 12.5 MHz lies in the lowest band
  always #40 link_ck = ~link_ck;
  // one command per rise, held across it, lines scrambled after
  task automatic send(input logic w, input logic r, input logic [5:0] a, input logic [7:0] op);
    @(negedge link_ck);
    mrw_req = w;
    mrr_req = r;
    mr_addr = a;
    mr_op = op;
    @(negedge link_ck);
    mrw_req = 1'b0;
    mrr_req = 1'b0;
    mr_addr = ~a;
    mr_op = ~op;
  endtask
endmodule // slm_ctrl_model

/* File: dv/slm_latency_regs_tb.sv */
// self-checking bench for the latency mode register block
`timescale 1ns/10ps
module slm_latency_regs_tb;
  import slm_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic sa = 1'b0;
  logic su = 1'b0;
  logic rdd = 1'b0;
  logic b32 = 1'b0;
  logic wrd = 1'b0;
  logic [5:0] rec = 6'h05;
  logic lck, mw, mr, mv, inv, lev, pre;
  logic [5:0] ma, rl, wl;
  logic [4:0] rtp;
  logic [7:0] op, md, got;
  int failures = 0, compares = 0, cycles = 0, reads = 0, rises = 0;
  logic [5:0] rl0 [8] = '{6'h06, 6'h0A, 6'h0E, 6'h14, 6'h18, 6'h1C, 6'h20, 6'h24};
  logic [5:0] rl1 [8] = '{6'h06, 6'h0C, 6'h10, 6'h16, 6'h1C, 6'h20, 6'h24, 6'h28};
  logic [5:0] wlb [8] = '{6'h04, 6'h08, 6'h0C, 6'h12, 6'h16, 6'h1A, 6'h1E, 6'h22};
  slm_ctrl_model ctrl (.link_ck(lck), .mrw_req(mw), .mrr_req(mr), .mr_addr(ma), .mr_op(op));
  slm_latency_regs uut (.clk(clk), .rst_n(rst_n), .link_ck(lck), .mrw_req(mw), .mrr_req(mr),
    .mr_addr(ma), .mr_op(op), .set_point_for_access(sa), .set_point_in_use(su),
    .rd_ap_done(rdd), .rd_ap_bl32(b32), .wr_ap_done(wrd), .recovery_cycles_after_store(rec),
    .mrr_data(md), .mrr_valid(mv), .read_latency(rl), .write_latency(wl),
    .read_to_precharge_cycles(rtp), .inversion_on_reads(inv), .leveling_on(lev),
    .precharge_start(pre));
  always #4 clk = ~clk;
  always @(posedge lck) rises++;
  always @(negedge clk) begin
    cycles++;
    if (mv === 1'b1) begin
      got = md;
      reads++;
    end
    if (cycles == 20000) begin
      failures++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic check(input string n, input logic [7:0] s, input logic [7:0] e);
    compares++;
    if (s !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic lat(input logic [5:0] r, input logic [5:0] w, input int p, input logic l);
    check("read_latency", {2'h0, rl}, {2'h0, r});
    check("write_latency", {2'h0, wl}, {2'h0, w});
    check("rtp", {3'h0, rtp}, 8'(p));
    check("leveling_on", {7'h0, lev}, {7'h0, l});
  endtask
  task automatic mrw(input logic [5:0] a, input logic [7:0] d);
    ctrl.send(1'b1, 1'b0, a, d);
    repeat (3) @(negedge clk);
  endtask
  task automatic mrr(input logic [5:0] a, input logic [7:0] e);
    int n;
    n = reads;
    ctrl.send(1'b0, 1'b1, a, 8'h00);
    repeat (3) @(negedge clk);
    check("mrr_count", 8'(reads - n), 8'h01);
    check("mrr_data", got, e);
  endtask
  // pulse a done just after a link fall, count link rises to the start pulse
  task automatic prech(input logic r, input logic b, input logic [7:0] n);
    @(negedge lck);
    @(negedge clk);
    rdd = r;
    b32 = b;
    wrd = ~r;
    rises = 0;
    @(negedge clk);
    rdd = 1'b0;
    wrd = 1'b0;
    for (int i = 0; i < 400 && pre !== 1'b1; i++) @(negedge clk);
    check("precharge_rises", 8'(rises), n);
  endtask
  initial begin
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    lat(6'h06, 6'h04, 8, 1'b0);
    for (int d = 0; d < 2; d++) begin
      mrw(SLM_ADDR_IO, d[0] ? 8'h71 : 8'h31);
      check("inversion", {7'h0, inv}, 8'(d));
      for (int c = 0; c < 8; c++) begin
        mrw(SLM_ADDR_LAT, {1'b0, c[0] ^ d[0], c[2:0], c[2:0]});
        lat(d[0] ? rl1[c] : rl0[c], (c[0] ^ d[0]) ? wlb[c] : 6'(4 + 2 * c),
          c < 4 ? 8 : 2 * c + 2, 1'b0);
      end
    end
    mrr(6'h05, 8'h00);
    mrw(6'h05, 8'hFF);
    lat(rl1[7], 6'h12, 16, 1'b0);
    sa = 1'b1;
    mrw(SLM_ADDR_LAT, 8'h7F);
    lat(rl1[7], 6'h12, 16, 1'b0);
    mrr(SLM_ADDR_LAT, 8'h7F);
    su = 1'b1;
    repeat (3) @(negedge clk);
    lat(rl0[7], wlb[7], 16, 1'b0);
    sa = 1'b0;
    mrr(SLM_ADDR_LAT, 8'h3F);
    prech(1'b1, 1'b0, 8'd16);
    prech(1'b1, 1'b1, 8'd24);
    prech(1'b0, 1'b0, 8'd5);
    sa = 1'b1;
    mrw(SLM_ADDR_LAT, 8'hFF);
    repeat (20) @(negedge clk);
    check("leveling_on", {7'h0, lev}, 8'h01);
    mrw(SLM_ADDR_LAT, 8'h7F);
    check("leveling_on", {7'h0, lev}, 8'h00);
    rst_n = 1'b0;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    lat(6'h06, 6'h04, 8, 1'b0);
    su = 1'b0;
    repeat (3) @(negedge clk);
    lat(6'h06, 6'h04, 8, 1'b0);
    tally_and_finish();
  end
endmodule // slm_latency_regs_tb
